// ==== rtl/eep_slave.sv ====
// Slave front end of the serial EEPROM: conditions, address match, acknowledge
// Summary of operation
// [R1] SDA fall with SCL high is start
// [R2] SDA rise with SCL high is stop
// [R3] Data stable while SCL high
// [R4] Ignore bus until a start
// [R5] Sample on rise, drive on fall
// [R6] Open drain: drive low only
// [R7] Class bits must be 1010
// [R8] Next bits match pins or address
// [R9] Last address bit: 1 read, 0 write
// [R10] Acknowledge matching address in ninth clock
// [R11] Acknowledge every written byte; code nacks data bytes while the latched write protect is high
// [R12] Read: shift byte, release, continue on ack
// [R13] Master ends read with nack, stop
// [R14] Master makes clock, start and stop
// [R15] Master starts only on idle bus
// [R16] Held in reset until supply valid
// [R17] Master waits 0.35 ms after power-up
// [R18] Write protect high blocks writes
// [R19] Undriven select pins read low; code relies on pulls outside, X passes through pins_seen
// [R20] Busy write cycle: released, no answer
// [R21] Busy poll nacked, acked when done
// [R22] Protect sampled before first data byte
// [R23] Start or stop mid-byte aborts byte
// [R24] Address mismatch: nack, ignore till start
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "eep_params.svh"
module eep_slave #(
  parameter int unsigned TWR_CYC = `EEP_TWR_CYC,
  parameter bit SIZE_USES_PINS = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  eep_link_if.device link,
  input wire logic supply_ok,
  input wire logic device_select_pin_0,
  input wire logic device_select_pin_1,
  input wire logic device_select_pin_2,
  input wire logic write_protect,
  input wire logic [7:0] read_data,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_is_addr,
  output logic [2:0] internal_addr_hi,
  output logic busy
);
  import eep_pkg::*;
  // ============================================================
  // Input synchronisers
  logic [1:0] scl_s_q, sda_s_q, wp_s_q, por_s_q;
  logic [2:0] pin_s1_q, pin_s2_q;
  logic scl_d1_q, sda_d1_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      wp_s_q <= 2'h0;
      por_s_q <= 2'h0;
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
      wp_s_q <= {wp_s_q[0], write_protect};
      por_s_q <= {por_s_q[0], supply_ok};
      pin_s1_q <= {device_select_pin_2, device_select_pin_1, device_select_pin_0};
      pin_s2_q <= pin_s1_q;
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
    end
  end
  // ============================================================
  // Bus events
  wire scl_now = scl_s_q[1];
  wire sda_now = sda_s_q[1];
  wire in_reset = ~por_s_q[1]; // R16
  wire scl_rise = scl_now & ~scl_d1_q; // R5
  wire scl_fall = ~scl_now & scl_d1_q; // R5
  wire start_ev = scl_now & scl_d1_q & sda_d1_q & ~sda_now; // R1
  wire stop_ev = scl_now & scl_d1_q & ~sda_d1_q & sda_now; // R2
  eep_slave_state_type state_q;
  logic [7:0] shreg_q;
  logic [3:0] bit_q;
  logic is_read_q, first_q, data_seen_q, wp_q, reject_q, wrote_q, sda_oe_q;
  logic [31:0] busy_cnt_q;
  wire [7:0] shift_in = {shreg_q[6:0], sda_now};
  // Undriven pins pulled low outside; X passes through the mask unchanged here
  wire [2:0] pins_seen = pin_s2_q & 3'h7; // R19
  // Matched at the fall after the eighth rise, when the register holds the whole byte
  wire class_ok = shreg_q[7:4] == `EEP_CLASS_CODE; // R7
  wire sel_ok = !SIZE_USES_PINS || shreg_q[3:1] == pins_seen; // R8
  wire last_bit = bit_q == 4'h7;
  wire busy_now = busy_cnt_q != 32'h0;
  // ============================================================
  // Byte engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= EEP_IDLE;
      shreg_q <= 8'h00;
      bit_q <= 4'h0;
      is_read_q <= 1'b0;
      first_q <= 1'b0;
      data_seen_q <= 1'b0;
      wp_q <= 1'b0;
      reject_q <= 1'b0;
      wrote_q <= 1'b0;
      sda_oe_q <= 1'b0;
      busy_cnt_q <= 32'h0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_is_addr <= 1'b0;
      internal_addr_hi <= 3'h0;
      busy <= 1'b0;
    end else if (in_reset) begin
      state_q <= EEP_IDLE; // R16
      sda_oe_q <= 1'b0;
      bit_q <= 4'h0;
      rx_valid <= 1'b0;
      busy_cnt_q <= 32'h0;
      busy <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      busy <= busy_now;
      if (busy_now)
        busy_cnt_q <= busy_cnt_q - 32'h1;
      if (start_ev) begin
        state_q <= busy_now ? EEP_IGNORE : EEP_RX; // R21 R23
        bit_q <= 4'h0;
        first_q <= 1'b1;
        data_seen_q <= 1'b0;
        reject_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_ev) begin
        state_q <= EEP_IDLE; // R23
        bit_q <= 4'h0;
        sda_oe_q <= 1'b0;
        if (wrote_q && !reject_q && !busy_now)
          busy_cnt_q <= TWR_CYC; // R20
        wrote_q <= 1'b0;
      end else begin
        unique case (state_q)
          EEP_IDLE, EEP_IGNORE: sda_oe_q <= 1'b0; // R4 R24
          EEP_RX: begin
            if (scl_rise) begin
              shreg_q <= shift_in;
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (first_q) begin
                if (class_ok && sel_ok) begin
                  state_q <= EEP_ACK;
                  sda_oe_q <= 1'b1; // R10
                  is_read_q <= shreg_q[0]; // R9
                  if (!SIZE_USES_PINS)
                    internal_addr_hi <= shreg_q[3:1];
                end else begin
                  state_q <= EEP_IGNORE; // R24
                end
              end else if (data_seen_q && wp_q) begin
                state_q <= EEP_IGNORE; // R18 R22
                reject_q <= 1'b1;
              end else begin
                state_q <= EEP_ACK;
                sda_oe_q <= 1'b1; // R11
                rx_data <= shreg_q;
                rx_valid <= 1'b1;
                rx_is_addr <= ~data_seen_q;
                if (data_seen_q)
                  wrote_q <= 1'b1;
                data_seen_q <= 1'b1;
              end
              first_q <= 1'b0;
            end
          end
          EEP_ACK: begin
            // Held low through the whole ninth period after a received byte; at its fall released for a write, first data bit driven for a read
            if (scl_fall) begin
              // Fall ending the memory address ack opens the first data byte
              if (!is_read_q && data_seen_q && !wrote_q)
                wp_q <= wp_s_q[1]; // R22
              if (is_read_q) begin
                state_q <= EEP_TX;
                shreg_q <= read_data;
                sda_oe_q <= ~read_data[7]; // R6 R12
                bit_q <= 4'h1;
              end else begin
                state_q <= EEP_RX;
                sda_oe_q <= 1'b0;
              end
            end
          end
          EEP_TX: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                state_q <= EEP_MACK;
                sda_oe_q <= 1'b0; // R12
              end else begin
                sda_oe_q <= ~shreg_q[3'(7 - bit_q)]; // R5
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          EEP_MACK: begin
            if (scl_rise) begin
              if (!sda_now) begin
                state_q <= EEP_ACK; // R12
                is_read_q <= 1'b1;
              end else begin
                state_q <= EEP_IGNORE; // R13
              end
            end
          end
          default: state_q <= EEP_IDLE;
        endcase
      end
    end
  end
  assign link.sda_s_o = 1'b0; // R6
  assign link.sda_s_oe = sda_oe_q; // R3
  wire unused_ok = last_bit;
endmodule

// ==== inc/eep_params.svh ====
// Timing counts and address field constants for the two-wire EEPROM front end
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH
`define EEP_CLASS_CODE 4'hA
`define EEP_CLK_NS 100
`define EEP_TWR_NS 4000000
`define EEP_TWR_CYC (`EEP_TWR_NS / `EEP_CLK_NS)
`define EEP_TPU_NS 350000
`define EEP_TPU_CYC ((`EEP_TPU_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS)
`define EEP_LINK_DIV 4
`define EEP_SEL_BITS 3
`endif

// ==== inc/eep_pkg.sv ====
// Types shared by both ends of the two-wire EEPROM link
package eep_pkg;
  typedef enum logic [2:0] {
    EEP_IDLE,
    EEP_RX,
    EEP_ACK,
    EEP_TX,
    EEP_MACK,
    EEP_IGNORE
  } eep_slave_state_type;
  typedef enum logic [3:0] {
    EEM_IDLE,
    EEM_START,
    EEM_LOW,
    EEM_HIGH,
    EEM_ACK_LOW,
    EEM_ACK_HIGH,
    EEM_STOP_LOW,
    EEM_STOP_HIGH,
    EEM_STOP_END
  } eep_master_state_type;
endpackage

// ==== inc/eep_link_if.sv ====
// Two-wire link between the EEPROM front end and its bus master
`timescale 1ns/100ps
interface eep_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Data line open drain with pull-up; clock driven both ways by scl_o when scl_oe, else pulled up
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o) ? 1'b0 : 1'b1;
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface

// ==== rtl/eep_master.sv ====
// Bus master end: APB orders, clock divider, start, byte, stop sequencing
`timescale 1ns/100ps
`include "eep_params.svh"
module eep_master #(
  parameter int unsigned DIV = `EEP_LINK_DIV,
  parameter int unsigned TPU_CYC = `EEP_TPU_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  eep_link_if.master link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import eep_pkg::*;
  // ============================================================
  // Registers: 0x00 command (write), 0x04 status/rx (read)
  // Command: [7:0] byte, [8] start first, [9] stop after, [10] read byte, [11] ack read
  logic [7:0] tx_q, rx_q;
  logic do_start_q, do_stop_q, do_read_q, ack_rd_q, nack_seen_q, go_q;
  logic [31:0] pu_cnt_q;
  logic [15:0] div_q;
  eep_master_state_type st_q;
  logic [3:0] bit_q;
  logic scl_q, sda_q;
  logic [1:0] sda_s_q;
  wire acc = psel & penable;
  wire wr_cmd = acc & pwrite & (paddr == 8'h00) & ~go_q & (pu_cnt_q == 32'h0); // R17
  wire tick = div_q == 16'(DIV - 1);
  wire sda_in = sda_s_q[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      sda_s_q <= 2'h3;
    end else begin
      sda_s_q <= {sda_s_q[0], link.sda};
      pready <= acc & ~pready & (!pwrite | paddr != 8'h00 | wr_cmd);
      pslverr <= acc & ~pready & paddr != 8'h00 & paddr != 8'h04;
      prdata <= {21'h0, nack_seen_q, pu_cnt_q != 32'h0, go_q, rx_q};
    end
  end
  // ============================================================
  // Sequencer; clock made by divider, the bus runs only from here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= EEM_IDLE;
      pu_cnt_q <= TPU_CYC;
      div_q <= 16'h0;
      bit_q <= 4'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      go_q <= 1'b0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      do_start_q <= 1'b0;
      do_stop_q <= 1'b0;
      do_read_q <= 1'b0;
      ack_rd_q <= 1'b0;
      nack_seen_q <= 1'b0;
    end else begin
      if (pu_cnt_q != 32'h0)
        pu_cnt_q <= pu_cnt_q - 32'h1; // R17
      div_q <= (tick || st_q == EEM_IDLE) ? 16'h0 : div_q + 16'h1;
      if (wr_cmd && !pready) begin
        go_q <= 1'b1;
        tx_q <= pwdata[7:0];
        do_start_q <= pwdata[8];
        do_stop_q <= pwdata[9];
        do_read_q <= pwdata[10];
        ack_rd_q <= pwdata[11];
        st_q <= pwdata[8] ? EEM_START : EEM_LOW;
        bit_q <= 4'h0;
      end else if (tick) begin
        unique case (st_q)
          EEM_IDLE: ;
          EEM_START: begin
            if (scl_q && sda_q) sda_q <= 1'b0; // R1 R14 R15
            else if (scl_q) begin scl_q <= 1'b0; st_q <= EEM_LOW; end
            else sda_q <= 1'b1;
            if (!scl_q && !sda_q) scl_q <= 1'b1;
            if (!scl_q && sda_q) scl_q <= 1'b1;
          end
          EEM_LOW: begin
            // Data changes only while the clock is low
            scl_q <= 1'b0;
            sda_q <= do_read_q ? 1'b1 : tx_q[7 - bit_q[2:0]]; // R3 R6
            st_q <= EEM_HIGH;
          end
          EEM_HIGH: begin
            scl_q <= 1'b1;
            if (scl_q) begin
              rx_q <= {rx_q[6:0], sda_in};
              bit_q <= bit_q + 4'h1;
              st_q <= bit_q == 4'h7 ? EEM_ACK_LOW : EEM_LOW;
              if (bit_q != 4'h7) scl_q <= 1'b0;
            end
          end
          EEM_ACK_LOW: begin
            scl_q <= 1'b0;
            sda_q <= do_read_q ? ~ack_rd_q : 1'b1; // R13
            st_q <= EEM_ACK_HIGH;
          end
          EEM_ACK_HIGH: begin
            scl_q <= 1'b1;
            if (scl_q) begin
              if (!do_read_q) nack_seen_q <= sda_in; // R21
              scl_q <= 1'b0;
              st_q <= do_stop_q ? EEM_STOP_LOW : EEM_IDLE;
              go_q <= do_stop_q;
            end
          end
          EEM_STOP_LOW: begin
            sda_q <= 1'b0;
            st_q <= EEM_STOP_HIGH;
          end
          EEM_STOP_HIGH: begin
            scl_q <= 1'b1;
            st_q <= EEM_STOP_END;
          end
          EEM_STOP_END: begin
            sda_q <= 1'b1; // R2
            st_q <= EEM_IDLE;
            go_q <= 1'b0;
          end
          default: st_q <= EEM_IDLE;
        endcase
      end
    end
  end
  assign link.scl_o = scl_q;
  assign link.scl_oe = 1'b1;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = ~sda_q;
  wire unused_ok = ^pwdata[31:12] | do_start_q;
endmodule

// ==== sim/eep_link_assertions.sv ====
// Wire-level checks on the two-wire link between the master and slave ends
`timescale 1ns/100ps
module eep_link_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  // ==========
  // Frame tracking
  logic sda_prev_q;
  logic active_q;
  wire start_ev = scl && sda_prev_q && !sda;
  wire stop_ev = scl && !sda_prev_q && sda;
  wire s_pull = sda_s_oe & ~sda_s_o;
  wire active_d = start_ev | (active_q & ~stop_ev);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_prev_q <= 1'b1;
      active_q <= 1'b0;
    end else begin
      sda_prev_q <= sda;
      active_q <= active_d;
    end
  end
  // ==========
  // Properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Master may park the clock low between commands, so the rise can come late
  sequence clk_pulse_s;
    ##[1:100] $rose(scl) ##[1:12] $fell(scl);
  endsequence
  idle_release_a: assert property (!active_q |-> !s_pull)
    else $error("slave pulls data line outside a frame");
  start_first_a: assert property ($fell(scl) |-> active_q)
    else $error("clock pulsed without a start");
  idle_scl_a: assert property (!active_q |-> scl)
    else $error("clock low after stop");
  fall_change_a: assert property ($changed(s_pull) |-> !scl && !$past(scl))
    else $error("slave data changed while clock high");
  push_only_a: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drives data line high");
  ack_hold_a: assert property ($rose(s_pull) |-> s_pull throughout clk_pulse_s)
    else $error("slave low bit not held through clock pulse");
  bus_free_a: assert property (stop_ev |=> (!start_ev) [*3])
    else $error("start too soon after stop");
  scl_high_a: assert property ($rose(scl) |=> scl [*3])
    else $error("clock high period too short");
endmodule

// ==== sim/tb_serial_eeprom_i2c_slave_front_end.sv ====
// Self-checking bench: master end ordered over APB against the slave end
`timescale 1ns/100ps
module tb_serial_eeprom_i2c_slave_front_end;
  // ==========
  // Signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic supply_ok = 1'b1;
  logic [2:0] pins = 3'b101;
  logic write_protect = 1'b0;
  logic [7:0] read_data = 8'h5A;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_is_addr, busy, rx_valid;
  int rx_count = 0;
  logic [7:0] rx_data;
  logic [31:0] st;
  logic err;
  int num_errors = 0;
  int check_count = 0;
  logic [7:0] bad [3] = '{8'hAC, 8'hBA, 8'h2A};
  eep_link_if link ();
  // Write cycle shortened so busy polling fits the run
  eep_slave #(.TWR_CYC(300)) i_eep_slave (.pclk(pclk), .presetn(presetn), .link(link), .supply_ok(supply_ok),
    .device_select_pin_0(pins[0]), .device_select_pin_1(pins[1]), .device_select_pin_2(pins[2]),
    .write_protect(write_protect), .read_data(read_data), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_is_addr(rx_is_addr), .internal_addr_hi(), .busy(busy));
  eep_master #(.DIV(4), .TPU_CYC(10)) i_eep_master (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  eep_link_assertions i_eep_link_assertions (.pclk(pclk), .presetn(presetn), .scl(link.scl), .sda(link.sda),
    .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe));
  initial begin
    forever #50 pclk = ~pclk;
  end
  // Counts accepted write bytes; the pulse stands one cycle
  always @(posedge pclk) begin
    if (rx_valid === 1'b1) rx_count <= rx_count + 1;
  end
  // ==========
  // Tasks
  task automatic close_out();
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic timed_out();
    num_errors++;
    close_out();
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 5000);
    if (pready !== 1'b1) timed_out();
    st = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps back-to-back calls from reassigning in one step
    @(posedge pclk);
  endtask
  task automatic send(input logic [11:0] c, input logic nack, input string name);
    int n;
    apb(1'b1, 8'h00, {20'h0, c});
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while (st[8] !== 1'b0 && n < 500);
    if (st[8] !== 1'b0) timed_out();
    check(name, {31'h0, st[10]}, {31'h0, nack});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (busy !== 1'b0) timed_out();
  endtask
  // ==========
  // Scenarios
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    check("powerup_wait", {31'h0, st[9]}, 32'h1);
    send(12'h1AA, 1'b0, "addr_ack");
    send(12'h012, 1'b0, "word_ack");
    check("word", {23'h0, rx_is_addr, rx_data}, 32'h112);
    send(12'h234, 1'b0, "data_ack");
    check("data", {23'h0, rx_is_addr, rx_data}, 32'h034);
    check("rx_count", rx_count, 32'h2);
    // Stop reaches the slave through its synchronisers after the master goes idle
    repeat (4) @(posedge pclk);
    check("busy", {31'h0, busy}, 32'h1);
    send(12'h3AA, 1'b1, "poll_busy");
    wait_idle();
    send(12'h3AA, 1'b0, "poll_done");
    foreach (bad[i]) send({4'h3, bad[i]}, 1'b1, "mismatch");
    send(12'h1AB, 1'b0, "read_ack");
    send(12'hC00, 1'b0, "read_more");
    check("byte1", {24'h0, st[7:0]}, 32'h5A);
    send(12'h600, 1'b0, "read_last");
    check("byte2", {24'h0, st[7:0]}, 32'h5A);
    write_protect <= 1'b1;
    send(12'h1AA, 1'b0, "wp_addr");
    send(12'h020, 1'b0, "wp_word");
    send(12'h277, 1'b1, "wp_data");
    repeat (4) @(posedge pclk);
    check("wp_busy", {31'h0, busy}, 32'h0);
    check("wp_count", rx_count, 32'h3);
    write_protect <= 1'b0;
    supply_ok <= 1'b0;
    repeat (4) @(posedge pclk);
    send(12'h3AA, 1'b1, "no_supply");
    supply_ok <= 1'b1;
    repeat (4) @(posedge pclk);
    send(12'h3AA, 1'b0, "supply_back");
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    close_out();
  end
endmodule
